// file: shared/led_status_pkg.sv
// constants and types for the switch status indicator logic
package led_status_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = 20;
  // base tick of 100 ms, all patterns are built from whole ticks
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = (CLOCK_HZ / 1000) * TICK_MS;
  // pattern lengths in milliseconds, as printed
  localparam int unsigned BOOT_BLINK_MS = 5000;
  localparam int unsigned BOOT_PAUSE_MS = 1000;
  localparam int unsigned ERROR_DARK_MS = 1900;
  localparam int unsigned ERROR_LIT_MS = 100;
  localparam int unsigned RING_BLINK_HALF_MS = 500;
  localparam int unsigned BLIP_DARK_MS = 1900;
  localparam int unsigned BLIP_LIT_MS = 100;
  localparam int unsigned RAPID_HALF_MS = 100;
  localparam int unsigned ACT_HALF_MS = 100;
  // pattern lengths in ticks
  localparam logic [5:0] BOOT_BLINK_TICKS = 6'(BOOT_BLINK_MS / TICK_MS);
  localparam logic [5:0] BOOT_PERIOD_TICKS = 6'((BOOT_BLINK_MS + BOOT_PAUSE_MS) / TICK_MS);
  localparam logic [5:0] ERROR_PERIOD_TICKS = 6'((ERROR_DARK_MS + ERROR_LIT_MS) / TICK_MS);
  localparam logic [5:0] ERROR_DARK_TICKS = 6'(ERROR_DARK_MS / TICK_MS);
  localparam logic [5:0] RING_HALF_TICKS = 6'(RING_BLINK_HALF_MS / TICK_MS);
  localparam logic [5:0] BLIP_PERIOD_TICKS = 6'((BLIP_DARK_MS + BLIP_LIT_MS) / TICK_MS);
  localparam logic [5:0] BLIP_DARK_TICKS = 6'(BLIP_DARK_MS / TICK_MS);
  localparam logic [5:0] RAPID_HALF_TICKS = 6'(RAPID_HALF_MS / TICK_MS);
  localparam logic [5:0] ACT_HALF_TICKS = 6'(ACT_HALF_MS / TICK_MS);
  localparam logic [5:0] TICKS_RESET = 6'h00;

  // ---------------------------------------------------------------
  // ports, events and speed codes
  // ---------------------------------------------------------------
  localparam int unsigned PORT_COUNT = 5;
  localparam int unsigned EVENT_COUNT = 4;
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // register map on the apb slave
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_ALARM_MASK = 8'h10;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [3:0] ALARM_MASK_RESET = 4'hf;
  // control bit positions
  localparam int unsigned CTL_IDENTIFY = 0;
  localparam int unsigned CTL_BOOT = 1;
  localparam int unsigned CTL_ERROR = 2;
  // event bit positions
  localparam int unsigned EV_SUPPLY = 0;
  localparam int unsigned EV_RING_BREAK = 1;
  localparam int unsigned EV_ERROR = 2;
  localparam int unsigned EV_LINK = 3;

  // health indicator pattern choice
  typedef enum logic [2:0] {
    HEALTH_ERROR,
    HEALTH_BOOT,
    HEALTH_IDENTIFY,
    HEALTH_STEADY,
    HEALTH_DARK
  } health_mode_t;

  // ring indicator pattern choice
  typedef enum logic [1:0] {
    RING_OFF,
    RING_ON,
    RING_BLINK,
    RING_BLIP
  } ring_mode_t;

endpackage

// file: verilog/led_pattern_timer.sv
// modulo phase counter advanced by an external tick, for one led pattern
`timescale 1ns/100ps
`default_nettype none
module led_pattern_timer
  import led_status_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  // pattern control
  input wire logic tick_in,
  input wire logic restart_in,
  input wire logic [5:0] period_in,
  // phase
  output logic [5:0] phase_out
);

  // ---------------------------------------------------------------
  // phase counter
  // ---------------------------------------------------------------
  logic [5:0] phase_q;

  // wraps at period, restart forces phase zero
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= TICKS_RESET;
    end else if (enable_in) begin
      if (restart_in) begin
        phase_q <= TICKS_RESET;
      end else if (tick_in) begin
        if (phase_q >= period_in - 6'h01) begin
          phase_q <= TICKS_RESET;
        end else begin
          phase_q <= phase_q + 6'h01;
        end
      end
    end
  end

  assign phase_out = phase_q;

endmodule
`default_nettype wire

// file: verilog/switch_status_led_control.sv
// status indicator logic for a five port ring switch
// How it works
// [R1] health lit steady when both supplies present and all configured rings intact
// [R2] health dark when a supply is absent or a ring segment fails
// [R3] identify request blinks health rapidly and continuously
// [R4] boot shows rapid blinking five seconds then one second dark, repeating
// [R5] internal error shows 1.9 seconds dark then 0.1 seconds lit, repeating
// [R6] health shows supply, ring and internal errors but not link loss; alarm output asserts only for selected error types
// [R7] ring lit steady when every enabled ring is intact
// [R8] ring dark when no ring is configured
// [R9] remote ring break blinks ring with equal lit and dark halves
// [R10] local ring break shows long dark short lit blip on ring
// [R11] port lit steady with link and no activity
// [R12] port dark without link
// [R13] port blinks with link and activity
// [R14] port colour: red gigabit, green 100, yellow 10
// [R15] each supply indicator lit exactly when its supply is present
// [R16] backup port disabled while ring complete, enabled at once on failure
// [R17] health precedence: error, boot, identify, then supply and ring status
`timescale 1ns/100ps
`default_nettype none
module switch_status_led_control
  import led_status_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clock_enable_in,
  // supplies, from pins
  input wire logic primary_supply_input_in,
  input wire logic secondary_supply_input_in,
  // ring status, same clock
  input wire logic ring_configured_in,
  input wire logic ring_broken_in,
  input wire logic ring_break_local_in,
  // port status, same clock
  input wire logic [PORT_COUNT-1:0] port_link_in,
  input wire logic [PORT_COUNT-1:0] port_activity_in,
  input wire logic [2*PORT_COUNT-1:0] port_speed_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // indicators
  output logic health_led_out,
  output logic ring_led_out,
  output logic primary_supply_led_out,
  output logic secondary_supply_led_out,
  output logic [PORT_COUNT-1:0] port_red_out,
  output logic [PORT_COUNT-1:0] port_green_out,
  // ring backup and alarm
  output logic backup_port_enable_out,
  output logic alarm_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // supply input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] p1_sync_q;
  logic [2:0] p2_sync_q;
  logic p1_q;
  logic p2_q;

  // three stages, a change counts once stages two and three agree
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      p1_sync_q <= 3'h0;
      p2_sync_q <= 3'h0;
      p1_q <= 1'b0;
      p2_q <= 1'b0;
    end else if (clock_enable_in) begin
      p1_sync_q <= {p1_sync_q[1:0], primary_supply_input_in};
      p2_sync_q <= {p2_sync_q[1:0], secondary_supply_input_in};
      if (p1_sync_q[1] == p1_sync_q[2]) begin
        p1_q <= p1_sync_q[2];
      end
      if (p2_sync_q[1] == p2_sync_q[2]) begin
        p2_q <= p2_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // 100 ms tick
  // ---------------------------------------------------------------
  localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);
  logic [22:0] tick_count_q;
  logic tick;

  // divides the clock down to the pattern base tick
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_count_q <= 23'h000000;
    end else if (clock_enable_in) begin
      if (tick) begin
        tick_count_q <= 23'h000000;
      end else begin
        tick_count_q <= tick_count_q + 23'h000001;
      end
    end
  end

  assign tick = (tick_count_q == TICK_LAST);

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [2:0] control_q;
  logic [EVENT_COUNT-1:0] event_q;
  logic [EVENT_COUNT-1:0] mask_q;
  logic [EVENT_COUNT-1:0] alarm_mask_q;
  logic [31:0] prdata_q;
  logic apb_write;
  logic apb_read;
  logic addr_hit;
  logic [EVENT_COUNT-1:0] event_set;

  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && penable && !pwrite;
  assign addr_hit = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_EVENT) || (paddr == ADDR_MASK) ||
                    (paddr == ADDR_ALARM_MASK);
  // zero wait state, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  // control, mask and alarm selection writes
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      control_q <= CONTROL_RESET[2:0];
      mask_q <= MASK_RESET;
      alarm_mask_q <= ALARM_MASK_RESET;
    end else if (clock_enable_in && apb_write) begin
      if (paddr == ADDR_CONTROL) begin
        control_q <= pwdata[2:0];
      end
      if (paddr == ADDR_MASK) begin
        mask_q <= pwdata[EVENT_COUNT-1:0];
      end
      if (paddr == ADDR_ALARM_MASK) begin
        alarm_mask_q <= pwdata[EVENT_COUNT-1:0];
      end
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_q <= 4'h0;
    end else if (clock_enable_in) begin
      if (apb_write && paddr == ADDR_EVENT) begin
        event_q <= (event_q & ~pwdata[EVENT_COUNT-1:0]) | event_set;
      end else begin
        event_q <= event_q | event_set;
      end
    end
  end

  // read data mux, registered on the edge that ends the setup phase
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (clock_enable_in && psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CONTROL: prdata_q <= {29'h0, control_q};
        ADDR_STATUS: prdata_q <= {24'h0, port_link_in, ring_broken_in, p2_q, p1_q};
        ADDR_EVENT: prdata_q <= {28'h0, event_q};
        ADDR_MASK: prdata_q <= {28'h0, mask_q};
        ADDR_ALARM_MASK: prdata_q <= {28'h0, alarm_mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status conditions and events
  // ---------------------------------------------------------------
  logic supplies_ok;
  logic ring_fault;
  logic ring_intact;
  logic identify_on;
  logic boot_on;
  logic error_on;
  logic [EVENT_COUNT-1:0] cond_q;
  logic [EVENT_COUNT-1:0] cond;

  assign supplies_ok = p1_q && p2_q;
  assign ring_fault = ring_configured_in && ring_broken_in;
  assign ring_intact = !ring_fault;
  assign identify_on = control_q[CTL_IDENTIFY];
  assign boot_on = control_q[CTL_BOOT];
  assign error_on = control_q[CTL_ERROR];
  assign cond = {~&port_link_in, error_on, ring_fault, ~supplies_ok};
  assign event_set = cond & ~cond_q;

  // previous conditions for rising edge events
  // reset as if every condition stands, so the synchroniser start-up makes no false event
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cond_q <= 4'hf;
    end else if (clock_enable_in) begin
      cond_q <= cond;
    end
  end

  // interrupt and alarm, the alarm follows only selected live errors
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
      alarm_out <= 1'b0;
    end else if (clock_enable_in) begin
      irq_out <= |(event_q & mask_q);
      alarm_out <= |(cond & alarm_mask_q); // R6
    end
  end

  // ---------------------------------------------------------------
  // pattern timers
  // ---------------------------------------------------------------
  logic [5:0] boot_phase;
  logic [5:0] error_phase;
  logic [5:0] ring_phase;
  logic [5:0] rapid_phase;
  logic [5:0] boot_period;
  logic [5:0] error_period;
  logic [5:0] ring_period;
  logic [5:0] rapid_period;

  assign boot_period = BOOT_PERIOD_TICKS;
  assign error_period = ERROR_PERIOD_TICKS;
  assign ring_period = ring_break_local_in ? BLIP_PERIOD_TICKS : (RING_HALF_TICKS << 1);
  assign rapid_period = RAPID_HALF_TICKS << 1;

  // boot pattern phase, restarts while the boot control bit is clear
  led_pattern_timer boot_timer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .enable_in(clock_enable_in),
    .tick_in(tick),
    .restart_in(!boot_on),
    .period_in(boot_period),
    .phase_out(boot_phase)
  );

  // error pattern phase
  led_pattern_timer error_timer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .enable_in(clock_enable_in),
    .tick_in(tick),
    .restart_in(!error_on),
    .period_in(error_period),
    .phase_out(error_phase)
  );

  // ring pattern phase
  led_pattern_timer ring_timer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .enable_in(clock_enable_in),
    .tick_in(tick),
    .restart_in(!ring_fault),
    .period_in(ring_period),
    .phase_out(ring_phase)
  );

  // shared rapid blink phase for identify, boot and port activity
  led_pattern_timer rapid_timer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .enable_in(clock_enable_in),
    .tick_in(tick),
    .restart_in(1'b0),
    .period_in(rapid_period),
    .phase_out(rapid_phase)
  );

  logic rapid_lit;
  assign rapid_lit = (rapid_phase < RAPID_HALF_TICKS);

  // ---------------------------------------------------------------
  // health indicator
  // ---------------------------------------------------------------
  health_mode_t health_mode;

  // pattern precedence
  always_comb begin
    if (error_on) begin
      health_mode = HEALTH_ERROR; // R17
    end else if (boot_on) begin
      health_mode = HEALTH_BOOT;
    end else if (identify_on) begin
      health_mode = HEALTH_IDENTIFY;
    end else if (supplies_ok && ring_intact) begin
      health_mode = HEALTH_STEADY;
    end else begin
      health_mode = HEALTH_DARK;
    end
  end

  // health output per pattern
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      health_led_out <= 1'b0;
    end else if (clock_enable_in) begin
      case (health_mode)
        HEALTH_ERROR: health_led_out <= (error_phase >= ERROR_DARK_TICKS); // R5
        HEALTH_BOOT: health_led_out <= (boot_phase < BOOT_BLINK_TICKS) && rapid_lit; // R4
        HEALTH_IDENTIFY: health_led_out <= rapid_lit; // R3
        HEALTH_STEADY: health_led_out <= 1'b1; // R1
        HEALTH_DARK: health_led_out <= 1'b0; // R2
        default: health_led_out <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // ring indicator and backup port
  // ---------------------------------------------------------------
  ring_mode_t ring_mode;

  always_comb begin
    if (!ring_configured_in) begin
      ring_mode = RING_OFF; // R8
    end else if (!ring_broken_in) begin
      ring_mode = RING_ON; // R7
    end else if (ring_break_local_in) begin
      ring_mode = RING_BLIP;
    end else begin
      ring_mode = RING_BLINK;
    end
  end

  // ring output per pattern
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ring_led_out <= 1'b0;
    end else if (clock_enable_in) begin
      case (ring_mode)
        RING_OFF: ring_led_out <= 1'b0;
        RING_ON: ring_led_out <= 1'b1;
        RING_BLINK: ring_led_out <= (ring_phase >= RING_HALF_TICKS); // R9
        RING_BLIP: ring_led_out <= (ring_phase >= BLIP_DARK_TICKS); // R10
        default: ring_led_out <= 1'b0;
      endcase
    end
  end

  // backup path opens in the same cycle the ring fails
  assign backup_port_enable_out = ring_fault; // R16

  // ---------------------------------------------------------------
  // supply and port indicators
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      primary_supply_led_out <= 1'b0;
      secondary_supply_led_out <= 1'b0;
    end else if (clock_enable_in) begin
      primary_supply_led_out <= p1_q; // R15
      secondary_supply_led_out <= p2_q; // R15
    end
  end

  // one lamp per port, red and green elements mix to yellow
  genvar gi;
  generate
    for (gi = 0; gi < PORT_COUNT; gi++) begin : g_port
      logic lit;
      logic [1:0] speed;
      assign speed = port_speed_in[2*gi +: 2];
      // steady with link, blinking with activity, dark without link
      assign lit = port_link_in[gi] && (!port_activity_in[gi] || rapid_lit); // R11 R12 R13
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          port_red_out[gi] <= 1'b0;
          port_green_out[gi] <= 1'b0;
        end else if (clock_enable_in) begin
          port_red_out[gi] <= lit && (speed != SPEED_100); // R14
          port_green_out[gi] <= lit && (speed != SPEED_1000); // R14
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_backup_follows_fault: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    backup_port_enable_out == (ring_configured_in && ring_broken_in))
    else $error("backup port not tracking ring fault"); // R16
  a_supply_led_match: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    clock_enable_in |=> primary_supply_led_out == $past(p1_q))
    else $error("primary supply led wrong"); // R15
  a_ring_unconfigured_dark: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && !ring_configured_in) |=> !ring_led_out)
    else $error("ring led lit with no ring"); // R8
  a_ring_intact_lit: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && ring_configured_in && !ring_broken_in) |=> ring_led_out)
    else $error("ring led dark on intact ring"); // R7
  a_health_steady_lit: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && !control_q[2] && !control_q[1] && !control_q[0]
     && p1_q && p2_q && !ring_fault) |=> health_led_out)
    else $error("health led not steady"); // R1
  a_health_dark_fault: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && control_q == 3'h0 && (!p1_q || !p2_q || ring_fault)) |=> !health_led_out)
    else $error("health led lit during fault"); // R2
  a_error_first: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && error_on && error_phase < ERROR_DARK_TICKS) |=> !health_led_out)
    else $error("error pattern not dominant"); // R17
  a_port_no_link_dark: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && !port_link_in[0]) |=> !port_red_out[0] && !port_green_out[0])
    else $error("port lamp lit without link"); // R12
  a_port_gig_red: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (clock_enable_in && port_link_in[0] && !port_activity_in[0] && port_speed_in[1:0] == SPEED_1000)
    |=> port_red_out[0] && !port_green_out[0])
    else $error("gigabit port not red"); // R11

endmodule
`default_nettype wire

// file: verif/tb_switch_status_led_control.sv
// self-checking bench for the switch status indicator logic
`timescale 1ns/100ps
`default_nettype none
module tb_switch_status_led_control;
  import led_status_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clock_in, reset_n_in, clock_enable_in, p1_in, p2_in;
  logic ring_cfg, ring_brk, ring_loc;
  logic [PORT_COUNT-1:0] link, act;
  logic [2*PORT_COUNT-1:0] spd;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic health, ring_led, p1_led, p2_led, backup, alarm, irq, err;
  logic [PORT_COUNT-1:0] red, green;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  switch_status_led_control u_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .clock_enable_in(clock_enable_in),
    .primary_supply_input_in(p1_in), .secondary_supply_input_in(p2_in),
    .ring_configured_in(ring_cfg), .ring_broken_in(ring_brk), .ring_break_local_in(ring_loc),
    .port_link_in(link), .port_activity_in(act), .port_speed_in(spd),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .health_led_out(health), .ring_led_out(ring_led), .primary_supply_led_out(p1_led),
    .secondary_supply_led_out(p2_led), .port_red_out(red), .port_green_out(green),
    .backup_port_enable_out(backup), .alarm_out(alarm), .irq_out(irq));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // a hang counts as a mismatch and closes the run
  always @(posedge clock_in) begin
    cycles++;
    if (cycles >= 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0; clock_enable_in = 1'b1; p1_in = 1'b1; p2_in = 1'b1;
    ring_cfg = 1'b0; ring_brk = 1'b0; ring_loc = 1'b0; link = '0; act = '0; spd = '0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    cyc(2);
    reset_n_in <= 1'b1;
    cyc(8);
    // register reset values
    apb(1'b0, ADDR_CONTROL, 32'h0); chk(rd, 32'h0000_0000, "control reset");
    apb(1'b0, ADDR_MASK, 32'h0); chk(rd, 32'h0000_0000, "irq mask reset");
    apb(1'b0, ADDR_ALARM_MASK, 32'h0); chk(rd, 32'h0000_000f, "alarm mask reset");
    apb(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0000_0003, "status supplies");
    // supplies good, no ring configured
    chk({p1_led, p2_led}, 2'b11, "supply leds");
    chk(health, 1'b1, "health steady");
    chk(ring_led, 1'b0, "ring dark unconfigured");
    // unmapped address refused
    apb(1'b1, 8'h14, 32'h7); chk(err, 1'b1, "unmapped write err");
    apb(1'b0, 8'h14, 32'h0); chk(err, 1'b1, "unmapped read err");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b0, ADDR_CONTROL, 32'h0); chk(rd, 32'h0, "control untouched");
    // ports 0..2 linked at 1000, 100, 10, ports 3..4 down
    @(posedge clock_in);
    link <= 5'b00111;
    spd <= {2'h0, 2'h0, SPEED_10, SPEED_100, SPEED_1000};
    cyc(4);
    chk(red, 5'b00101, "port red");
    chk(green, 5'b00110, "port green");
    apb(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0000_003b, "status links");
    // ring configured and intact, then a remote break
    @(posedge clock_in);
    ring_cfg <= 1'b1;
    cyc(4);
    chk({ring_led, health, backup}, 3'b110, "ring intact");
    @(posedge clock_in);
    ring_brk <= 1'b1;
    @(posedge clock_in);
    chk(backup, 1'b1, "backup enabled at once");
    cyc(3);
    chk({health, ring_led}, 2'b00, "health dark, ring blink dark half");
    apb(1'b0, ADDR_EVENT, 32'h0); chk(rd[EV_RING_BREAK], 1'b1, "ring event");
    @(posedge clock_in);
    ring_brk <= 1'b0;
    // clear events, unmask supply loss, drop secondary supply
    apb(1'b1, ADDR_EVENT, 32'hf);
    apb(1'b1, ADDR_MASK, 32'h1);
    cyc(3);
    chk(irq, 1'b0, "irq idle");
    @(posedge clock_in);
    p2_in <= 1'b0;
    cyc(8);
    chk({p1_led, p2_led}, 2'b10, "secondary led dark");
    chk(health, 1'b0, "health dark on supply loss");
    chk({irq, alarm}, 2'b11, "irq and alarm raised");
    apb(1'b0, ADDR_EVENT, 32'h0); chk(rd, 32'h0000_0001, "supply event");
    apb(1'b1, ADDR_ALARM_MASK, 32'h0);
    cyc(3);
    chk(alarm, 1'b0, "alarm masked off");
    apb(1'b1, ADDR_EVENT, 32'h1);
    cyc(3);
    chk(irq, 1'b0, "irq cleared");
    @(posedge clock_in);
    p2_in <= 1'b1;
    cyc(8);
    chk(health, 1'b1, "health back");
    // error wins over boot and identify: starts with the long dark span
    apb(1'b1, ADDR_CONTROL, 32'h7);
    cyc(4);
    chk(health, 1'b0, "error pattern dark");
    cyc(200);
    chk(health, 1'b0, "error pattern still dark");
    apb(1'b0, ADDR_CONTROL, 32'h0); chk(rd, 32'h0000_0007, "control readback");
    apb(1'b0, ADDR_EVENT, 32'h0); chk(rd[EV_ERROR], 1'b1, "error event");
    apb(1'b1, ADDR_CONTROL, 32'h0);
    cyc(4);
    chk(health, 1'b1, "health steady again");
    // identify wins over dark status; run is far shorter than a tick, so lit half
    apb(1'b1, ADDR_CONTROL, 32'h1);
    @(posedge clock_in);
    p2_in <= 1'b0;
    cyc(8);
    chk(health, 1'b1, "identify over supply loss");
    apb(1'b1, ADDR_CONTROL, 32'h0);
    cyc(3);
    chk(health, 1'b0, "dark once identify ends");
    // enable low freezes the supply path
    @(posedge clock_in);
    clock_enable_in <= 1'b0;
    p2_in <= 1'b1;
    cyc(8);
    chk(p2_led, 1'b0, "frozen while enable low");
    @(posedge clock_in);
    clock_enable_in <= 1'b1;
    cyc(8);
    chk(p2_led, 1'b1, "resumes with enable");
    end_sim();
  end
endmodule
`default_nettype wire
